// ===== src/sled_defs.svh
// register map, field positions, reset values and timing for the indicator
`ifndef SLED_DEFS_SVH
`define SLED_DEFS_SVH

`define SLED_ADDR_W        16
`define SLED_CTRL_ADDR     16'h404C
`define SLED_STAT_ADDR     16'h4048
`define SLED_CTRL_RESET    16'hC026
`define SLED_CTRL_WMASK    16'hC33F

`define SLED_SRC_HI        15
`define SLED_SRC_LO        14
`define SLED_PAT_HI        9
`define SLED_PAT_LO        8
`define SLED_LEN_HI        5
`define SLED_LEN_LO        4
`define SLED_DUR_HI        3
`define SLED_DUR_LO        2
`define SLED_RAT_HI        1
`define SLED_RAT_LO        0

`define SLED_CLK_PERIOD_NS 50
`define SLED_TICK_NS       62500000
`define SLED_TICK_CYCLES   (`SLED_TICK_NS / `SLED_CLK_PERIOD_NS)
`define SLED_PRE_W         21
`define SLED_OTP_SHOW_MS   1000
`define SLED_OTP_SHOW_TICKS 5'h10

`endif

// ===== src/sled_pkg.sv
// types shared by the status indicator pattern generator
`default_nettype none
package sled_pkg;

  typedef enum logic [1:0] {
    SLED_SRC_OFF    = 2'b00,
    SLED_SRC_POWER  = 2'b01,
    SLED_SRC_RSVD   = 2'b10,
    SLED_SRC_MANUAL = 2'b11
  } sled_src_t;

  typedef enum logic [1:0] {
    SLED_PAT_OFF    = 2'b00,
    SLED_PAT_STEADY = 2'b01,
    SLED_PAT_CONT   = 2'b10,
    SLED_PAT_BURST  = 2'b11
  } sled_pat_t;

  typedef enum logic [1:0] {
    SLED_ST_ON   = 2'b00,
    SLED_ST_OFF  = 2'b01,
    SLED_ST_DONE = 2'b10
  } sled_state_t;

  typedef struct packed {
    logic [15:0]  ctrl;
    logic [31:0]  rdata;
    logic [20:0]  pre;
    sled_state_t  st;
    logic [6:0]   cnt;
    logic [2:0]   pulses;
    logic [4:0]   otp_cnt;
    logic         otp_prev;
    logic         led;
  } sled_regs_t;

endpackage : sled_pkg
`default_nettype wire

// ===== src/sled_gen.sv
// status indicator pattern generator with apb register access
//
// Function
// - source field 00 off, 01 power state, 11 manual, 10 reserved; resets manual.
// - indicator also signals completion of the one-time memory auto-program.
// - manual pattern field only applies while source selects manual control.
// - pattern 00 off, 01 steady, 10 endless pulses, 11 burst; resets 00.
// - burst length 00 one, 01 two, 10 four, 11 seven pulses; resets 10.
// - pulse on time 1 s, 250 ms, 125 ms, 62.5 ms; resets 01.
// - on:off ratio 1:1, 1:2, 1:3, 1:7; resets 10.
`timescale 1ns/1ps
`default_nettype none
`include "sled_defs.svh"

module sled_gen #(
  parameter int TICK_CYCLES = `SLED_TICK_CYCLES
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    ce_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [`SLED_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  input  wire logic                    power_state_led_in,
  input  wire logic                    otp_prog_done_in,
  output logic                         indicator_out
);

  sled_pkg::sled_regs_t r;
  sled_pkg::sled_regs_t next_r;

  sled_pkg::sled_src_t indicator_source_select;
  sled_pkg::sled_pat_t indicator_manual_pattern;
  logic [1:0]          indicator_burst_length;
  logic [1:0]          indicator_on_duration;
  logic [1:0]          indicator_on_off_ratio;

  logic        hit_ctrl;
  logic        hit_stat;
  logic        setup;
  logic        wr_ctrl;
  logic        tick;
  logic        restart;
  logic [15:0] wval;
  logic [6:0]  on_ticks;
  logic [6:0]  off_ticks;
  logic [2:0]  burst_n;
  logic [15:0] status;
  logic        pattern_level;
  logic        flash_on;
  logic        otp_rise;

  assign indicator_source_select  =
    sled_pkg::sled_src_t'(r.ctrl[`SLED_SRC_HI:`SLED_SRC_LO]);
  assign indicator_manual_pattern =
    sled_pkg::sled_pat_t'(r.ctrl[`SLED_PAT_HI:`SLED_PAT_LO]);
  assign indicator_burst_length   = r.ctrl[`SLED_LEN_HI:`SLED_LEN_LO];
  assign indicator_on_duration    = r.ctrl[`SLED_DUR_HI:`SLED_DUR_LO];
  assign indicator_on_off_ratio   = r.ctrl[`SLED_RAT_HI:`SLED_RAT_LO];

  // zero-wait slave: read data is captured in the setup cycle
  assign hit_ctrl    = (paddr_in == `SLED_CTRL_ADDR);
  assign hit_stat    = (paddr_in == `SLED_STAT_ADDR);
  assign setup       = psel_in & ~penable_in;
  assign pready_out  = ce_in;
  // the status word is read-only: writes to it are dropped, not refused
  assign pslverr_out = psel_in & penable_in & ~(hit_ctrl | hit_stat);
  assign wr_ctrl     = ce_in & psel_in & penable_in & pwrite_in & hit_ctrl;
  assign wval        = pwdata_in[15:0] & `SLED_CTRL_WMASK;

  // any change to a writable control field restarts at the on phase
  assign restart = wr_ctrl &&
    ((wval & `SLED_CTRL_WMASK) != (r.ctrl & `SLED_CTRL_WMASK));

  // slow time base: one tick per 62.5 ms, the shortest on time
  // the prescaler is 21 bits wide, so TICK_CYCLES must not exceed 2**21
  assign tick = (r.pre == `SLED_PRE_W'(TICK_CYCLES - 1));

  always_comb begin
    case (indicator_on_duration)
      2'b00:   on_ticks = 7'h10;
      2'b01:   on_ticks = 7'h04;
      2'b10:   on_ticks = 7'h02;
      default: on_ticks = 7'h01;
    endcase
  end

  always_comb begin
    case (indicator_on_off_ratio)
      2'b00:   off_ticks = on_ticks;
      2'b01:   off_ticks = 7'(on_ticks * 7'h02);
      2'b10:   off_ticks = 7'(on_ticks * 7'h03);
      default: off_ticks = 7'(on_ticks * 7'h07);
    endcase
  end

  always_comb begin
    case (indicator_burst_length)
      2'b00:   burst_n = 3'h1;
      2'b01:   burst_n = 3'h2;
      2'b10:   burst_n = 3'h4;
      default: burst_n = 3'h7;
    endcase
  end

  // continuous and burst share one phase machine; only the burst ends
  always_comb begin
    case (indicator_manual_pattern)
      sled_pkg::SLED_PAT_OFF:    pattern_level = 1'b0;
      sled_pkg::SLED_PAT_STEADY: pattern_level = 1'b1;
      sled_pkg::SLED_PAT_CONT,
      sled_pkg::SLED_PAT_BURST:
        pattern_level = (r.st == sled_pkg::SLED_ST_ON);
      default:                   pattern_level = 1'b0;
    endcase
  end

  assign status = {9'h000, (r.otp_cnt != 5'h00), (r.st ==
                   sled_pkg::SLED_ST_DONE), r.pulses, r.st == 
                   sled_pkg::SLED_ST_ON, r.led};

  // the flash overrides every source and leaves the pattern timer alone
  assign flash_on = (r.otp_cnt != 5'h00);
  assign otp_rise = otp_prog_done_in & ~r.otp_prev;

  always_comb begin
    next_r = r;
    next_r.otp_prev = otp_prog_done_in;
    if (setup) begin
      if (hit_ctrl) begin
        next_r.rdata = {16'h0000, r.ctrl & `SLED_CTRL_WMASK};
      end else if (hit_stat) begin
        next_r.rdata = {16'h0000, status};
      end else begin
        next_r.rdata = 32'h0000_0000;
      end
    end
    if (wr_ctrl) begin
      next_r.ctrl = wval;
    end

    next_r.pre = tick ? `SLED_PRE_W'(0) : r.pre + `SLED_PRE_W'(1);

    // completion flash: forced on for one second after a rising edge;
    // a fresh edge reloads the count and wins over a tick in that cycle
    if (otp_rise) begin
      next_r.otp_cnt = `SLED_OTP_SHOW_TICKS;
    end else if (tick && flash_on) begin
      next_r.otp_cnt = r.otp_cnt - 5'h01;
    end

    if (restart) begin
      next_r.st     = sled_pkg::SLED_ST_ON;
      next_r.cnt    = 7'h00;
      next_r.pulses = 3'h0;
      next_r.pre    = `SLED_PRE_W'(0);
    end else if (tick) begin
      case (r.st)
        sled_pkg::SLED_ST_ON: begin
          if (r.cnt == on_ticks - 7'h01) begin
            next_r.st     = sled_pkg::SLED_ST_OFF;
            next_r.cnt    = 7'h00;
            next_r.pulses = r.pulses + 3'h1;
          end else begin
            next_r.cnt = r.cnt + 7'h01;
          end
        end
        sled_pkg::SLED_ST_OFF: begin
          if (r.cnt == off_ticks - 7'h01) begin
            next_r.cnt = 7'h00;
            // a finished burst stays dark until a write changes a field
            if (indicator_manual_pattern == sled_pkg::SLED_PAT_BURST &&
                r.pulses == burst_n) begin
              next_r.st = sled_pkg::SLED_ST_DONE;
            end else begin
              next_r.st = sled_pkg::SLED_ST_ON;
              if (indicator_manual_pattern == sled_pkg::SLED_PAT_CONT) begin
                next_r.pulses = 3'h0;
              end
            end
          end else begin
            next_r.cnt = r.cnt + 7'h01;
          end
        end
        sled_pkg::SLED_ST_DONE: next_r.st = sled_pkg::SLED_ST_DONE;
        default:                next_r.st = sled_pkg::SLED_ST_ON;
      endcase
    end

    if (flash_on) begin
      next_r.led = 1'b1;
    end else begin
      case (indicator_source_select)
        sled_pkg::SLED_SRC_OFF:    next_r.led = 1'b0;
        sled_pkg::SLED_SRC_POWER:  next_r.led = power_state_led_in;
        sled_pkg::SLED_SRC_MANUAL: next_r.led = pattern_level;
        default:                   next_r.led = 1'b0;
      endcase
    end
  end

  // clock enable low freezes every flop, bus answer included
  // reset wins over a low clock enable so the block can always be cleared
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r          <= '0;
      r.ctrl     <= `SLED_CTRL_RESET;
      r.st       <= sled_pkg::SLED_ST_ON;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign prdata_out    = r.rdata;
  assign indicator_out = r.led;

endmodule : sled_gen
`default_nettype wire

// ===== test/sled_led_model.sv
// board indicator model: measures the on and off runs it is driven with
`timescale 1ns/1ps
`default_nettype none
module sled_led_model (
  input  wire logic clk_in,
  input  wire logic clr_in,
  input  wire logic led_in,
  output int        hi_out,
  output int        lo_out,
  output int        cnt_out
);
  int   run = 0;
  logic prev = 1'b0;
  always_ff @(posedge clk_in) begin
    prev <= led_in;
    run <= (led_in != prev) ? 1 : run + 1;
    if (led_in != prev && led_in) lo_out <= run;
    if (led_in != prev && !led_in) hi_out <= run;
    cnt_out <= clr_in ? 0 : cnt_out + int'(led_in && !prev);
  end
endmodule : sled_led_model
`default_nettype wire

// ===== test/sled_gen_chk.sv
// port assertions for the status indicator pattern generator
`timescale 1ns/1ps
`default_nettype none
module sled_gen_chk (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        power_state_led_in,
  input wire logic        otp_prog_done_in,
  input wire logic        indicator_out
);
  logic [15:0] c;
  logic        ac;
  logic        wr;
  logic        otp_seen;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  assign ac = psel_in && penable_in && ce_in;
  assign wr = ac && pwrite_in && paddr_in == 16'h404C;
  // shadow of the control word, so assertions can see the mode
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) c <= 16'hC026;
    else if (wr) c <= pwdata_in[15:0] & 16'hC33F;
  end
  // the flash outlives the done level, so the quiet-output checks stop
  // once the done level has been seen
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) otp_seen <= 1'b0;
    else if (otp_prog_done_in) otp_seen <= 1'b1;
  end
  ready_follow_a: assert property (pready_out == ce_in)
    else $error("pready");
  err_map_a: assert property (ac && paddr_in != 16'h404C && paddr_in !=
    16'h4048 |-> pslverr_out) else $error("no slave error");
  rd_ctrl_a: assert property (ac && !pwrite_in && paddr_in == 16'h404C
    |-> prdata_out == {16'h0, c}) else $error("control read");
  src_off_a: assert property ((!c[14] && !otp_seen)[*3]
    |-> !indicator_out) else $error("source off lit");
  power_src_a: assert property ((c[15:14] == 2'b01 && !otp_seen &&
    $stable(power_state_led_in))[*3] |-> indicator_out ==
    power_state_led_in) else $error("power source");
  steady_on_a: assert property ((c[15:14] == 2'b11 &&
    c[9:8] == 2'b01)[*3] |-> indicator_out) else $error("steady");
  man_off_a: assert property ((c[15:14] == 2'b11 && c[9:8] == 2'b00
    && !otp_seen)[*3] |-> !indicator_out) else $error("man off");
  pattern_restart_a: assert property (wr && pwdata_in[15:14] == 2'b11 &&
    pwdata_in[9] && (pwdata_in[15:0] & 16'hC33F) != c
    |-> ##[1:2] indicator_out) else $error("no restart");
  otp_flash_a: assert property ($rose(otp_prog_done_in)
    |-> ##[1:3] indicator_out) else $error("no flash");
endmodule : sled_gen_chk
bind sled_gen sled_gen_chk chk (.*);
`default_nettype wire

// ===== test/sled_gen_tb_top.sv
// self-checking bench for the status indicator pattern generator
`timescale 1ns/1ps
`default_nettype none
module sled_gen_tb_top;
  localparam int T = 4;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, pwr_led = 1'b0, otp = 1'b0, clr = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] addr = 16'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, rq;
  logic        rdy, err, re, led;
  int          hi, lo, cnt, fail_count = 0, checks = 0;
  always #25 clk = ~clk;
  sled_gen #(.TICK_CYCLES(T)) uut (.ref_clk_in(clk), .rst_in(rst),
    .ce_in(ce), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(addr), .pwdata_in(wd), .prdata_out(rd), .pready_out(rdy),
    .pslverr_out(err), .power_state_led_in(pwr_led),
    .otp_prog_done_in(otp), .indicator_out(led));
  sled_led_model led_m (.clk_in(clk), .clr_in(clr), .led_in(led),
    .hi_out(hi), .lo_out(lo), .cnt_out(cnt));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one apb transfer; an idle edge after it keeps requests apart
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rq = rd;
    re = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic t_regs;
    apb(1'b0, 16'h404C, 32'h0);
    check(rq, 32'h0000C026);
    check(re, 1'b0);
    apb(1'b1, 16'h4000, 32'hFFFF);
    check(re, 1'b1);
    apb(1'b1, 16'h404C, 32'hFFFF);
    apb(1'b0, 16'h404C, 32'h0);
    check(rq, 32'h0000C33F);
  endtask : t_regs
  task automatic t_src;
    logic [15:0] v[6] = '{16'h4100, 16'h4100, 16'h8100, 16'h0100,
                          16'hC100, 16'hC000};
    logic [5:0]  p = 6'b000001;
    logic [5:0]  x = 6'b010001;
    for (int i = 0; i < 6; i++) begin
      pwr_led <= p[i];
      apb(1'b1, 16'h404C, {16'h0, v[i]});
      cyc(4);
      check(led, x[i]);
    end
  endtask : t_src
  task automatic t_pulse;
    int on, off;
    for (int d = 0; d < 4; d++) begin
      for (int r = 0; r < 4; r++) begin
        on = (d == 0 ? 16 : 8 >> d) * T;
        off = on * (r == 3 ? 7 : r + 1);
        apb(1'b1, 16'h404C, 32'hC200 | (d << 2) | r);
        cyc(2 * (on + off) + 4);
        check(hi, on);
        check(lo, off);
      end
    end
  endtask : t_pulse
  task automatic t_burst;
    int n[4] = '{1, 2, 4, 7};
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, 16'h404C, 32'hC000);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      apb(1'b1, 16'h404C, 32'hC30C | (l << 4));
      cyc(80);
      check(cnt, n[l]);
      check(led, 1'b0);
      apb(1'b0, 16'h4048, 32'h0);
      check(rq, 32'h20 | (n[l] << 2));
    end
  endtask : t_burst
  // enable low must freeze the pattern and hold the bus off; a reset in
  // mid-run then brings back the control defaults
  task automatic t_ce;
    logic held;
    apb(1'b1, 16'h404C, 32'hC20C);
    cyc(3);
    ce <= 1'b0;
    cyc(1);
    held = led;
    cyc(4);
    check(led, held);
    check(rdy, 1'b0);
    ce <= 1'b1;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    check(led, 1'b0);
    check(rdy, 1'b1);
    apb(1'b0, 16'h404C, 32'h0);
    check(rq, 32'h0000C026);
  endtask : t_ce
  task automatic t_otp;
    apb(1'b1, 16'h404C, 32'h0);
    otp <= 1'b1;
    cyc(4);
    check(led, 1'b1);
    cyc(16 * T - 8);
    check(led, 1'b1);
    cyc(12);
    check(led, 1'b0);
  endtask : t_otp
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    cyc(2);
    rst <= 1'b0;
    t_regs;
    t_src;
    t_pulse;
    t_burst;
    t_ce;
    t_otp;
    finish_test;
  end
  initial begin
    cyc(20000);
    fail_count++;
    finish_test;
  end
endmodule : sled_gen_tb_top
`default_nettype wire
